// file: design/ctm_clock_timing_mode_control.sv
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - two basic clocks, high and low frequency
// - all system clocks derive from selected clock
// - two-stage prescaler then twenty-one-stage divider
// - stage seven input chosen by mode and selects
// - chain cleared on reset, stop entry, release
// - low-speed modes feed low-frequency clock to stage seven
// - warm-up after fast stop feeds stage six to stage seven
// - machine cycle is four main clock states
// - instructions last one to ten machine cycles
// - controller runs oscillators, modes set by registers
// - single-clock: only fast oscillator, pins released
// - single-clock main clock is the fast clock
// - reset enters fast single-oscillator run
// - select bit switches dual mode slow/fast
// - fast-off and halt modes gate first stage
module ctm_clock_timing_mode_control
    import ctm_pkg::*;
#(
    parameter int WARMUP_STAGE = 14
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic high_freq_basic_clock,
    input wire logic low_freq_basic_clock,
    input wire logic stop_release_pin,
    input wire logic halt_wake,
    input wire logic [3:0] instr_cycles,
    output logic hf_osc_enable,
    output logic lf_osc_enable,
    output logic lf_pins_released,
    output logic main_clk_tick,
    output logic [1:0] machine_state,
    output logic instr_done,
    output logic [LOWER_W+UPPER_W-1:0] divider_state,
    output logic [2:0] mode_state
);

    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        unique case (addr)
            OFS_SYS_CTRL_FIRST: reg_index = 3'h1;
            OFS_SYS_CTRL_SECOND: reg_index = 3'h2;
            OFS_TIME_BASE_TIMER_CONTROL: reg_index = 3'h3;
            OFS_STATUS: reg_index = 3'h4;
            OFS_DIVIDER: reg_index = 3'h5;
            default: reg_index = 3'h0;
        endcase
    endfunction : reg_index

    function automatic logic [3:0] clamp_cycles(input logic [3:0] n);
        if (n < MIN_INSTR_CYCLES) begin
            clamp_cycles = MIN_INSTR_CYCLES;
        end else if (n > MAX_INSTR_CYCLES) begin
            clamp_cycles = MAX_INSTR_CYCLES;
        end else begin
            clamp_cycles = n;
        end
    endfunction : clamp_cycles

    ctm_ctrl_s ctrl;
    ctm_mode_e mode;
    ctm_mode_e resume_mode;
    ctm_mode_e next_mode;
    ctm_mode_e run_target;
    ctm_mode_e mode_eff;
    logic stop_from_fast;
    logic [LOWER_W-1:0] lower;
    logic [UPPER_W-1:0] upper;
    logic [1:0] state;
    logic [3:0] remaining;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic w_lane0_q;

    // bus decode
    wire logic aw_take = awvalid && awready;
    wire logic w_take = wvalid && wready;
    wire logic do_write = (aw_held || aw_take) && (w_held || w_take);
    wire logic [7:0] wr_addr = aw_held ? aw_addr_q : awaddr;
    wire logic [31:0] wr_data = w_held ? w_data_q : wdata;
    wire logic wr_lane0 = w_held ? w_lane0_q : wstrb[0];
    wire logic [2:0] wr_idx = reg_index(wr_addr);
    wire logic wr_ok = do_write && wr_lane0;
    wire logic wr_first = wr_ok && (wr_idx == 3'h1);
    wire logic wr_second = wr_ok && (wr_idx == 3'h2);
    wire logic wr_tbt = wr_ok && (wr_idx == 3'h3);
    wire logic ar_take = arvalid && arready;
    wire logic [2:0] rd_idx = reg_index(araddr);

    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;

    // clock tree: effective mode, gating and the stage seven mux
    assign mode_eff = (mode == STOP_WARMUP) ? resume_mode : mode;
    wire logic is_fast = (mode_eff == FAST_RUN_SINGLE_OSC) || (mode_eff == FAST_RUN_DUAL_OSC);
    wire logic is_slow = (mode_eff == LOW_SPEED_RUN_BOTH_OSC) || (mode_eff == LOW_SPEED_RUN_FAST_OSC_OFF);
    wire logic is_halt = (mode_eff == LOW_SPEED_HALT_BOTH_OSC) || (mode_eff == LOW_SPEED_HALT_FAST_OSC_OFF);
    wire logic fast_off = (mode_eff == LOW_SPEED_RUN_FAST_OSC_OFF) || (mode_eff == LOW_SPEED_HALT_FAST_OSC_OFF);
    assign hf_osc_enable = (mode != OSC_STOP) && !fast_off;
    assign lf_osc_enable = (mode != OSC_STOP) && (mode_eff != FAST_RUN_SINGLE_OSC);
    assign lf_pins_released = (mode_eff == FAST_RUN_SINGLE_OSC);
    wire logic hf_stage1 = high_freq_basic_clock && hf_osc_enable && !is_halt;
    wire logic lf_tick = low_freq_basic_clock && lf_osc_enable;
    wire logic stage6_carry = hf_stage1 && (&lower);
    wire logic warm_from_fast = (mode == STOP_WARMUP) && stop_from_fast;
    wire logic stage7_in = (is_slow || is_halt) ? lf_tick :
        warm_from_fast ? stage6_carry :
        ctrl.divider_stage7_source_select ? lf_tick : stage6_carry;
    wire logic warmup_done = (mode == STOP_WARMUP) && upper[WARMUP_STAGE-7];

    // main clock follows the selected basic clock; halted outside run modes
    assign main_clk_tick = (mode == mode_eff) && (is_fast ? high_freq_basic_clock :
        is_slow ? lf_tick : 1'b0);
    wire logic boundary = main_clk_tick && (state == 2'(STATES_PER_CYCLE - 1));

    // mode controller
    assign run_target = !ctrl.lf_osc_en ? FAST_RUN_SINGLE_OSC :
        !ctrl.core_clock_source_select ? FAST_RUN_DUAL_OSC :
        ctrl.hf_osc_en ? LOW_SPEED_RUN_BOTH_OSC : LOW_SPEED_RUN_FAST_OSC_OFF;

    always_comb begin
        next_mode = mode;
        unique case (mode)
            FAST_RUN_SINGLE_OSC, FAST_RUN_DUAL_OSC, LOW_SPEED_RUN_BOTH_OSC, LOW_SPEED_RUN_FAST_OSC_OFF: begin
                if (boundary) begin
                    if (ctrl.stop_req) begin
                        next_mode = OSC_STOP;
                    end else if (ctrl.halt_req && run_target == LOW_SPEED_RUN_BOTH_OSC) begin
                        next_mode = LOW_SPEED_HALT_BOTH_OSC;
                    end else if (ctrl.halt_req && run_target == LOW_SPEED_RUN_FAST_OSC_OFF) begin
                        next_mode = LOW_SPEED_HALT_FAST_OSC_OFF;
                    end else begin
                        next_mode = run_target;
                    end
                end
            end
            LOW_SPEED_HALT_BOTH_OSC, LOW_SPEED_HALT_FAST_OSC_OFF: begin
                // the core clock is stopped here, so no boundary can be waited for
                if (halt_wake) begin
                    next_mode = run_target;
                end
            end
            OSC_STOP: begin
                if (stop_release_pin) begin
                    next_mode = STOP_WARMUP;
                end
            end
            STOP_WARMUP: begin
                if (warmup_done) begin
                    next_mode = resume_mode;
                end
            end
        endcase
    end

    wire logic stop_edge = (mode != OSC_STOP && next_mode == OSC_STOP) || (mode == OSC_STOP && next_mode != OSC_STOP);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= FAST_RUN_SINGLE_OSC;
            resume_mode <= FAST_RUN_SINGLE_OSC;
            stop_from_fast <= 1'b0;
        end else begin
            mode <= next_mode;
            if (next_mode == OSC_STOP && mode != OSC_STOP) begin
                resume_mode <= mode;
                stop_from_fast <= is_fast;
            end
        end
    end

    // prescaler and divider chain
    always_ff @(posedge aclk) begin
        if (!aresetn || stop_edge) begin
            lower <= '0;
            upper <= '0;
        end else begin
            lower <= lower + LOWER_W'(hf_stage1);
            upper <= upper + UPPER_W'(stage7_in);
        end
    end

    // machine cycle states and instruction length counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= 2'h0;
            remaining <= MIN_INSTR_CYCLES;
        end else begin
            state <= state + 2'(main_clk_tick);
            if (boundary) begin
                remaining <= (remaining <= MIN_INSTR_CYCLES) ? clamp_cycles(instr_cycles) : remaining - 4'h1;
            end
        end
    end
    assign instr_done = boundary && (remaining == MIN_INSTR_CYCLES);

    // control bits; a software write of one wins over a hardware clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
        end else begin
            if (wr_first) begin
                ctrl.stop_req <= wr_data[BIT_STOP_REQ];
            end else if (warmup_done) begin
                ctrl.stop_req <= 1'b0;
            end
            if (wr_second) begin
                ctrl.lf_osc_en <= wr_data[BIT_LF_OSC_EN];
                ctrl.hf_osc_en <= wr_data[BIT_HF_OSC_EN];
                ctrl.core_clock_source_select <= wr_data[BIT_CORE_CLOCK_SOURCE_SELECT];
                ctrl.halt_req <= wr_data[BIT_HALT_REQ];
            end
            if (!(wr_second && wr_data[BIT_HALT_REQ]) && is_halt && halt_wake) begin
                ctrl.halt_req <= 1'b0;
            end
            if (wr_tbt) begin
                ctrl.divider_stage7_source_select <= wr_data[BIT_DIVIDER_STAGE7_SOURCE_SELECT];
            end
        end
    end

    // AXI4-Lite slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_lane0_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= 32'h0000_0000;
        end else begin
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (wr_idx == 3'h0) ? RESP_SLVERR : RESP_OKAY;
            end else begin
                if (aw_take) begin
                    aw_held <= 1'b1;
                    aw_addr_q <= awaddr;
                end
                if (w_take) begin
                    w_held <= 1'b1;
                    w_data_q <= wdata;
                    w_lane0_q <= wstrb[0];
                end
                if (bvalid && bready) begin
                    bvalid <= 1'b0;
                end
            end
            if (ar_take) begin
                rvalid <= 1'b1;
                rresp <= (rd_idx == 3'h0) ? RESP_SLVERR : RESP_OKAY;
                unique case (rd_idx)
                    3'h1: rdata <= {31'h0, ctrl.stop_req};
                    3'h2: rdata <= {28'h0, ctrl.halt_req, ctrl.core_clock_source_select, ctrl.hf_osc_en,
                        ctrl.lf_osc_en};
                    3'h3: rdata <= {31'h0, ctrl.divider_stage7_source_select};
                    3'h4: rdata <= {27'h0, state, mode};
                    3'h5: rdata <= {9'h0, upper, lower};
                    default: rdata <= 32'h0000_0000;
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    assign machine_state = state;
    assign divider_state = {upper, lower};
    assign mode_state = mode;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    reset_mode_a: assert property ($rose(aresetn) |-> mode == FAST_RUN_SINGLE_OSC)
        else $error("mode after reset is not fast single-oscillator run");
    single_pins_a: assert property (mode == FAST_RUN_SINGLE_OSC |-> !lf_osc_enable && lf_pins_released)
        else $error("low-frequency oscillator active in single-clock mode");
    single_clock_a: assert property (mode == FAST_RUN_SINGLE_OSC |-> main_clk_tick == high_freq_basic_clock)
        else $error("main clock not from fast clock in single-clock mode");
    stop_cleared_a: assert property (mode == OSC_STOP |-> lower == '0 && upper == '0)
        else $error("divider chain not clear in stop");
    release_clear_a: assert property (mode == OSC_STOP && stop_release_pin |=> mode == STOP_WARMUP && lower == '0
        && upper == '0)
        else $error("divider chain not cleared on stop release");
    slow_stage7_a: assert property ((is_slow || is_halt) && mode != OSC_STOP && !stop_edge |=> upper == $past(upper)
        + UPPER_W'($past(lf_tick)))
        else $error("stage seven not fed by low-frequency clock in low-speed mode");
    warm_stage7_a: assert property (warm_from_fast && !warmup_done |=> upper == $past(upper)
        + UPPER_W'($past(stage6_carry)))
        else $error("stage seven not fed by stage six during warm-up");
    gated_first_a: assert property (is_halt || fast_off |=> $stable(lower) || $past(stop_edge))
        else $error("first divider stage clocked while gated");
    cycle_wrap_a: assert property (boundary |=> state == 2'h0)
        else $error("machine cycle did not wrap after four states");
    run_switch_a: assert property ((is_fast || is_slow) && mode == mode_eff && mode != $past(mode)
        && $past(mode) != STOP_WARMUP && $past(mode) != LOW_SPEED_HALT_BOTH_OSC
        && $past(mode) != LOW_SPEED_HALT_FAST_OSC_OFF |-> $past(boundary))
        else $error("run mode changed away from a machine-cycle boundary");
    dual_slow_a: assert property (mode == FAST_RUN_DUAL_OSC && boundary && run_target == LOW_SPEED_RUN_BOTH_OSC
        && !ctrl.stop_req && !ctrl.halt_req |=> mode == LOW_SPEED_RUN_BOTH_OSC)
        else $error("select bit did not switch dual mode to low-speed run");
    instr_len_a: assert property (instr_done |=> remaining == (($past(instr_cycles) == 4'h0) ? MIN_INSTR_CYCLES
        : ($past(instr_cycles) > MAX_INSTR_CYCLES) ? MAX_INSTR_CYCLES : $past(instr_cycles)))
        else $error("next instruction length not held within one to ten cycles");

endmodule : ctm_clock_timing_mode_control

`default_nettype wire

// file: include/ctm_pkg.sv
package ctm_pkg;

    // register byte offsets on the AXI4-Lite port
    localparam logic [7:0] OFS_SYS_CTRL_FIRST = 8'h00;
    localparam logic [7:0] OFS_SYS_CTRL_SECOND = 8'h04;
    localparam logic [7:0] OFS_TIME_BASE_TIMER_CONTROL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_DIVIDER = 8'h10;

    // field positions
    localparam int BIT_STOP_REQ = 0;
    localparam int BIT_LF_OSC_EN = 0;
    localparam int BIT_HF_OSC_EN = 1;
    localparam int BIT_CORE_CLOCK_SOURCE_SELECT = 2;
    localparam int BIT_HALT_REQ = 3;
    localparam int BIT_DIVIDER_STAGE7_SOURCE_SELECT = 0;

    // chain geometry
    localparam int PRESCALER_STAGES = 2;
    localparam int DIVIDER_STAGES = 21;
    localparam int LOWER_W = PRESCALER_STAGES + 6;
    localparam int UPPER_W = DIVIDER_STAGES - 6;
    localparam int STATES_PER_CYCLE = 4;
    localparam logic [3:0] MIN_INSTR_CYCLES = 4'h1;
    localparam logic [3:0] MAX_INSTR_CYCLES = 4'ha;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        FAST_RUN_SINGLE_OSC,
        FAST_RUN_DUAL_OSC,
        LOW_SPEED_RUN_BOTH_OSC,
        LOW_SPEED_RUN_FAST_OSC_OFF,
        LOW_SPEED_HALT_BOTH_OSC,
        LOW_SPEED_HALT_FAST_OSC_OFF,
        OSC_STOP,
        STOP_WARMUP
    } ctm_mode_e;

    typedef struct packed {
        logic stop_req;
        logic lf_osc_en;
        logic hf_osc_en;
        logic core_clock_source_select;
        logic halt_req;
        logic divider_stage7_source_select;
    } ctm_ctrl_s;

    localparam ctm_ctrl_s CTRL_RESET = '{stop_req: 1'b0, lf_osc_en: 1'b0, hf_osc_en: 1'b1,
        core_clock_source_select: 1'b0, halt_req: 1'b0, divider_stage7_source_select: 1'b0};

endpackage : ctm_pkg

// file: test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %0h got %0h", nm, (e), (g)); end end

module tb_top
    import ctm_pkg::*;
;
    localparam logic [31:0] LF = 32'h1 << BIT_LF_OSC_EN;
    localparam logic [31:0] HF = 32'h1 << BIT_HF_OSC_EN;
    localparam logic [31:0] SEL = 32'h1 << BIT_CORE_CLOCK_SOURCE_SELECT;
    localparam logic [31:0] HALT = 32'h1 << BIT_HALT_REQ;
    logic aclk = 1'b0;
    logic aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, instr_cycles;
    logic [1:0] bresp, rresp, machine_state;
    logic hf_on, lf_on, hf_tick, lf_tick, stop_release_pin, halt_wake;
    logic hf_osc_enable, lf_osc_enable, lf_pins_released, main_clk_tick, instr_done;
    logic [2:0] lf_cnt, mode_state;
    logic [LOWER_W+UPPER_W-1:0] divider_state;
    int failures, tests_run;

    always #4 aclk = ~aclk;

    // fast tick every other cycle, slow tick every eighth, so the two machine cycle lengths differ
    always @(posedge aclk) begin
        lf_cnt <= lf_cnt + 3'h1;
        hf_tick <= hf_on & ~hf_tick;
        lf_tick <= lf_on & (lf_cnt == 3'h7);
    end

    ctm_clock_timing_mode_control #(.WARMUP_STAGE(8)) ctm_clock_timing_mode_control_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .high_freq_basic_clock(hf_tick), .low_freq_basic_clock(lf_tick),
        .stop_release_pin(stop_release_pin), .halt_wake(halt_wake), .instr_cycles(instr_cycles),
        .hf_osc_enable(hf_osc_enable), .lf_osc_enable(lf_osc_enable), .lf_pins_released(lf_pins_released),
        .main_clk_tick(main_clk_tick), .machine_state(machine_state), .instr_done(instr_done),
        .divider_state(divider_state), .mode_state(mode_state));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic timeout_hit(input string what);
        failures++;
        $display("BAD %s exp event got none", what);
        end_of_test();
    endtask : timeout_hit

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 100 && !(aw_ok && w_ok); n++) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        if (!(aw_ok && w_ok)) timeout_hit("write accept");
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (bvalid !== 1'b1 && n < 100);
        if (bvalid !== 1'b1) timeout_hit("bvalid");
        `CHK("bresp", er, bresp)
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (arready !== 1'b1 && n < 100);
        if (arready !== 1'b1) timeout_hit("arready");
        arvalid <= 1'b0;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (rvalid !== 1'b1 && n < 100);
        if (rvalid !== 1'b1) timeout_hit("rvalid");
        `CHK("rresp", er, rresp)
        d = rdata;
        rready <= 1'b0;
    endtask : axi_read

    task automatic wait_mode(input logic [2:0] m, input int lim);
        int n;
        for (n = 0; n < lim && mode_state !== m; n++) @(posedge aclk);
        `CHK("mode_state", m, mode_state)
        if (mode_state !== m) end_of_test();
    endtask : wait_mode

    task automatic wait_done(output int c);
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (instr_done !== 1'b1 && c < 2000);
        if (instr_done !== 1'b1) timeout_hit("instr_done");
        `CHK("state at done", 2'h3, machine_state)
    endtask : wait_done

    task automatic count_ticks(input int span, input int exp_n);
        int n;
        n = 0;
        repeat (span) begin
            @(posedge aclk);
            if (main_clk_tick === 1'b1) n++;
        end
        `CHK("main ticks", exp_n, n)
    endtask : count_ticks

    task automatic t_reset(input bit again);
        logic [31:0] d;
        if (again) begin
            // reset from stop, so the mode, fast osc, pins and stop request checked below differ from their values before reset
            axi_write(OFS_SYS_CTRL_FIRST, 32'h1 << BIT_STOP_REQ, RESP_OKAY);
            wait_mode(OSC_STOP, 200);
            aresetn <= 1'b0;
            repeat (2) @(posedge aclk);
        end
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK("mode after reset", FAST_RUN_SINGLE_OSC, mode_state)
        `CHK("divider after reset", '0, divider_state)
        `CHK("fast osc", 1'b1, hf_osc_enable)
        `CHK("slow osc", 1'b0, lf_osc_enable)
        `CHK("pins released", 1'b1, lf_pins_released)
        axi_read(OFS_SYS_CTRL_SECOND, RESP_OKAY, d);
        `CHK("ctrl second reset", HF, d)
        axi_read(OFS_SYS_CTRL_FIRST, RESP_OKAY, d);
        `CHK("stop request reset", 32'h0, d)
        axi_read(OFS_TIME_BASE_TIMER_CONTROL, RESP_OKAY, d);
        `CHK("stage7 select reset", 32'h0, d)
        axi_write(8'h20, 32'h1, RESP_SLVERR);
        axi_read(8'h20, RESP_SLVERR, d);
        `CHK("unmapped read", 32'h0, d)
        $display("test reset done");
    endtask : t_reset

    task automatic t_cycle();
        int c;
        logic [3:0] lens [4] = '{4'h1, 4'ha, 4'h0, 4'hf};
        int expect_len [4] = '{8, 80, 8, 80};
        hf_on <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            instr_cycles <= lens[i];
            wait_done(c);
            wait_done(c);
            wait_done(c);
            `CHK("instruction length", expect_len[i], c)
        end
        count_ticks(16, 8);
        $display("test machine_cycle done");
    endtask : t_cycle

    task automatic t_dual();
        logic [31:0] d;
        logic [LOWER_W-1:0] lo;
        logic [UPPER_W-1:0] hi;
        int c;
        lf_on <= 1'b1;
        instr_cycles <= 4'h1;
        axi_write(OFS_SYS_CTRL_SECOND, LF | HF, RESP_OKAY);
        wait_mode(FAST_RUN_DUAL_OSC, 200);
        `CHK("slow osc on", 1'b1, lf_osc_enable)
        `CHK("pins held", 1'b0, lf_pins_released)
        axi_read(OFS_STATUS, RESP_OKAY, d);
        `CHK("status mode", FAST_RUN_DUAL_OSC, d[2:0])
        // slow clock long stable and dual mode running, so stage seven may take it now
        axi_write(OFS_TIME_BASE_TIMER_CONTROL, 32'h1, RESP_OKAY);
        hi = divider_state[LOWER_W+UPPER_W-1:LOWER_W];
        repeat (64) @(posedge aclk);
        `CHK("stage7 from slow", UPPER_W'(32'h8), UPPER_W'(divider_state[LOWER_W+UPPER_W-1:LOWER_W] - hi))
        axi_write(OFS_TIME_BASE_TIMER_CONTROL, 32'h0, RESP_OKAY);
        axi_write(OFS_SYS_CTRL_SECOND, LF | HF | SEL, RESP_OKAY);
        wait_mode(LOW_SPEED_RUN_BOTH_OSC, 200);
        wait_done(c);
        wait_done(c);
        `CHK("slow machine cycle", 32, c)
        count_ticks(32, 4);
        // stage7 select left at 0: only a forced slow feed moves the upper chain now
        axi_write(OFS_SYS_CTRL_SECOND, LF | SEL, RESP_OKAY);
        wait_mode(LOW_SPEED_RUN_FAST_OSC_OFF, 200);
        `CHK("fast osc off", 1'b0, hf_osc_enable)
        lo = divider_state[LOWER_W-1:0];
        hi = divider_state[LOWER_W+UPPER_W-1:LOWER_W];
        wait_done(c);
        wait_done(c);
        `CHK("lower stages held", lo, divider_state[LOWER_W-1:0])
        `CHK("upper stages run", 1'b1, divider_state[LOWER_W+UPPER_W-1:LOWER_W] != hi)
        axi_write(OFS_SYS_CTRL_SECOND, LF | SEL | HALT, RESP_OKAY);
        wait_mode(LOW_SPEED_HALT_FAST_OSC_OFF, 200);
        lo = divider_state[LOWER_W-1:0];
        repeat (16) @(posedge aclk);
        `CHK("lower stages halted", lo, divider_state[LOWER_W-1:0])
        halt_wake <= 1'b1;
        wait_mode(LOW_SPEED_RUN_FAST_OSC_OFF, 20);
        halt_wake <= 1'b0;
        axi_read(OFS_SYS_CTRL_SECOND, RESP_OKAY, d);
        `CHK("halt cleared", LF | SEL, d)
        axi_write(OFS_SYS_CTRL_SECOND, LF | HF | SEL, RESP_OKAY);
        wait_mode(LOW_SPEED_RUN_BOTH_OSC, 200);
        axi_write(OFS_SYS_CTRL_SECOND, LF | HF, RESP_OKAY);
        wait_mode(FAST_RUN_DUAL_OSC, 200);
        axi_write(OFS_SYS_CTRL_SECOND, HF, RESP_OKAY);
        wait_mode(FAST_RUN_SINGLE_OSC, 200);
        `CHK("pins free again", 1'b1, lf_pins_released)
        $display("test dual_clock done");
    endtask : t_dual

    task automatic t_stop();
        logic [31:0] d;
        lf_on <= 1'b0;
        axi_write(OFS_SYS_CTRL_FIRST, 32'h1 << BIT_STOP_REQ, RESP_OKAY);
        wait_mode(OSC_STOP, 200);
        `CHK("divider at stop", '0, divider_state)
        `CHK("fast osc stopped", 1'b0, hf_osc_enable)
        axi_read(OFS_DIVIDER, RESP_OKAY, d);
        `CHK("divider reg in stop", 32'h0, d)
        stop_release_pin <= 1'b1;
        wait_mode(STOP_WARMUP, 20);
        `CHK("divider at release", '0, divider_state)
        stop_release_pin <= 1'b0;
        // slow ticks are off, so warm-up can only end through the stage six feed
        wait_mode(FAST_RUN_SINGLE_OSC, 5000);
        axi_read(OFS_SYS_CTRL_FIRST, RESP_OKAY, d);
        `CHK("stop request cleared", 32'h0, d)
        $display("test stop done");
    endtask : t_stop

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, hf_on, lf_on} = '0;
        {hf_tick, lf_tick, stop_release_pin, halt_wake} = '0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        instr_cycles = 4'h1;
        lf_cnt = 3'h0;
        failures = 0;
        tests_run = 0;
        repeat (10) @(posedge aclk);
        t_reset(1'b0);
        t_cycle();
        t_dual();
        t_stop();
        t_reset(1'b1);
        end_of_test();
    end
endmodule : tb_top

`undef CHK
`default_nettype wire
